// >>> banked_data_memory_map_pkg.sv
// Purpose: Shared constants for the banked data memory map block.
// Assumes: File addresses are 9 bits: two bank bits above a 7-bit bank offset.
// Notes:   APB byte address of a bank offset is four times that offset.
package banked_data_memory_map_pkg;
  // Bank offsets of core registers, mirrored in all four banks except 01h, which is shared by banks 0/2 and by banks 1/3
  localparam logic [6:0] OFS_INDIRECT_ACCESS_PORT  = 7'h00;
  localparam logic [6:0] OFS_TIMER_OR_OPTION       = 7'h01;
  localparam logic [6:0] OFS_PROGRAM_COUNTER_LOW   = 7'h02;
  localparam logic [6:0] OFS_CORE_STATUS_FLAGS     = 7'h03;
  localparam logic [6:0] OFS_INDIRECT_ADDR_POINTER = 7'h04;
  localparam logic [6:0] OFS_PC_HIGH_LATCH         = 7'h0a;
  localparam logic [6:0] OFS_INTERRUPT_CONTROL     = 7'h0b;
  // Shared RAM window at the top of every bank
  localparam logic [6:0] OFS_SHARED_FIRST          = 7'h70;
  // Reserved holes in bank 3
  localparam logic [8:0] ADDR_HOLE_FIRST           = 9'h18d;
  localparam logic [8:0] ADDR_HOLE_LAST            = 9'h18f;
  // Status field positions
  localparam int STATUS_INDIRECT_BANK_BIT = 7;
  localparam int STATUS_BANK_HIGH_BIT     = 6;
  localparam int STATUS_BANK_LOW_BIT      = 5;
  // Reset values
  localparam logic [7:0] STATUS_POR_VALUE         = 8'h18;
  localparam logic [7:0] PC_LOW_RESET_VALUE       = 8'h00;
  localparam logic [4:0] PC_HIGH_LATCH_RESET      = 5'h00;
  localparam logic [7:0] INTERRUPT_CONTROL_RESET_VALUE       = 8'h00;
  localparam logic [7:0] POINTER_RESET_VALUE      = 8'h00;
  // Size of the file address space
  localparam int FILE_WORDS = 512;
endpackage : banked_data_memory_map_pkg

// >>> banked_data_memory_map.sv
// Purpose: Banked data memory of a small microcontroller, reached over APB.
// Assumes: APB clocked by clk_in; paddr bits [8:2] carry the 7-bit bank offset.
// Notes:   The bank comes from the status register bank bits, as for direct core accesses; offset 00h takes it from status bit 7 and the pointer.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps

// What this block does
// - Special function registers are plain storage that hold their value until written or reset.
// - Unimplemented addresses read as all zeros and ignore writes.
// - Offset 00h of each bank has no storage and redirects the access through the pointer.
// - Status loads 0001 1xxx on power-on reset and 000q quuu on any other reset.
// - Two status bits select bank 0 to 3, each bank covering offsets up to 7Fh.
// - Mirrored registers are one physical register seen through every alias.
module banked_data_memory_map
  import banked_data_memory_map_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        other_reset_in,
  input  wire logic        timeout_flag_in,
  input  wire logic        power_down_flag_in,
  input  wire logic        core_flags_we_in,
  input  wire logic [2:0]  core_flags_in,
  input  wire logic        pc_low_we_in,
  input  wire logic [7:0]  pc_low_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic      [7:0]  status_out,
  output logic      [7:0]  pc_low_out,
  output logic      [4:0]  pc_high_latch_out,
  output logic      [7:0]  interrupt_control_out,
  output logic      [7:0]  indirect_address_pointer_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic reset_meta;
  logic reset_sync_n;

  // Two flops so the release is clean against clk_in
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reset_meta   <= 1'b0;
      reset_sync_n <= 1'b0;
    end else begin
      reset_meta   <= 1'b1;
      reset_sync_n <= reset_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helpers

  // Folds mirrors and the shared window onto one canonical address
  function automatic logic [8:0] canonical(input logic [8:0] addr);
    logic [6:0] ofs;
    ofs = addr[6:0];
    if (ofs >= OFS_SHARED_FIRST) canonical = {2'b00, ofs};
    else if (ofs == OFS_TIMER_OR_OPTION) canonical = {1'b0, addr[7], ofs};
    else if (ofs == OFS_PROGRAM_COUNTER_LOW || ofs == OFS_CORE_STATUS_FLAGS ||
             ofs == OFS_INDIRECT_ADDR_POINTER || ofs == OFS_PC_HIGH_LATCH ||
             ofs == OFS_INTERRUPT_CONTROL) canonical = {2'b00, ofs};
    else canonical = addr;
  endfunction : canonical

  // True where the map has a real cell
  function automatic logic implemented(input logic [8:0] addr);
    implemented = (addr[6:0] != OFS_INDIRECT_ACCESS_PORT) &&
                  !(addr >= ADDR_HOLE_FIRST && addr <= ADDR_HOLE_LAST);
  endfunction : implemented

  ////////////////////////////////////////////////////////////////////////////
  // Effective address of the current APB request
  logic [8:0] direct_addr;
  logic [8:0] effective_addr;
  logic [8:0] canon_addr;
  logic       cell_present;
  logic       out_of_range;

  // Bank bits pick the bank; offset 00h goes through the pointer instead
  always_comb begin
    direct_addr = {status_out[STATUS_BANK_HIGH_BIT], status_out[STATUS_BANK_LOW_BIT],
                   paddr_in[8:2]};
    if (paddr_in[8:2] == OFS_INDIRECT_ACCESS_PORT) begin
      effective_addr = {status_out[STATUS_INDIRECT_BANK_BIT], indirect_address_pointer_out};
    end else begin
      effective_addr = direct_addr;
    end
    canon_addr   = canonical(effective_addr);
    cell_present = implemented(effective_addr);
    out_of_range = (paddr_in[31:9] != 23'h000000) || (paddr_in[1:0] != 2'h0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage for general purpose and peripheral locations
  logic [7:0] file_ram [FILE_WORDS];
  logic       write_now;
  logic [7:0] wbyte;

  assign write_now = psel_in && penable_in && pready_out && pwrite_in && !out_of_range;
  assign wbyte     = pwdata_in[7:0];

  // Plain static cells; not reset, like ordinary RAM
  always_ff @(posedge clk_in) begin
    if (write_now && cell_present) begin
      file_ram[canon_addr] <= wbyte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core registers
  logic [7:0] next_status;
  logic [7:0] next_pc_low;
  logic [4:0] next_pc_high_latch;
  logic [7:0] next_interrupt_control;
  logic [7:0] next_pointer;
  logic       core_hit;

  // Software writes first, then core updates so the core wins a same-cycle clash
  always_comb begin
    next_status        = status_out;
    next_pc_low        = pc_low_out;
    next_pc_high_latch = pc_high_latch_out;
    next_interrupt_control        = interrupt_control_out;
    next_pointer       = indirect_address_pointer_out;
    core_hit           = write_now && cell_present;
    if (core_hit) begin
      case (canon_addr)
        {2'b00, OFS_CORE_STATUS_FLAGS}: begin
          // Timeout and power-down bits are read-only to software
          next_status = {wbyte[7:5], status_out[4:3], wbyte[2:0]};
        end
        {2'b00, OFS_PROGRAM_COUNTER_LOW}: begin
          next_pc_low = wbyte;
        end
        {2'b00, OFS_PC_HIGH_LATCH}: begin
          next_pc_high_latch = wbyte[4:0];
        end
        {2'b00, OFS_INTERRUPT_CONTROL}: begin
          next_interrupt_control = wbyte;
        end
        {2'b00, OFS_INDIRECT_ADDR_POINTER}: begin
          next_pointer = wbyte;
        end
        default: begin
        end
      endcase
    end
    if (core_flags_we_in) begin
      next_status[2:0] = core_flags_in;
    end
    if (pc_low_we_in) begin
      next_pc_low = pc_low_in;
    end
    // Non power-on reset: keep low flags, load cause bits, clear PC low and latch, clear interrupt control except bit 0, keep the pointer
    if (other_reset_in) begin
      next_status        = {3'b000, timeout_flag_in, power_down_flag_in, status_out[2:0]};
      next_pc_low        = PC_LOW_RESET_VALUE;
      next_pc_high_latch = PC_HIGH_LATCH_RESET;
      next_interrupt_control        = {INTERRUPT_CONTROL_RESET_VALUE[7:1], interrupt_control_out[0]};
      next_pointer       = indirect_address_pointer_out;
    end
  end

  // Power-on values; undefined low status bits are forced to zero here
  always_ff @(posedge clk_in or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      status_out                   <= STATUS_POR_VALUE;
      pc_low_out                   <= PC_LOW_RESET_VALUE;
      pc_high_latch_out            <= PC_HIGH_LATCH_RESET;
      interrupt_control_out        <= INTERRUPT_CONTROL_RESET_VALUE;
      indirect_address_pointer_out <= POINTER_RESET_VALUE;
    end else begin
      status_out                   <= next_status;
      pc_low_out                   <= next_pc_low;
      pc_high_latch_out            <= next_pc_high_latch;
      interrupt_control_out        <= next_interrupt_control;
      indirect_address_pointer_out <= next_pointer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: data sampled in setup, pready raised for the access cycle
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [7:0]  read_byte;

  always_comb begin
    case (canon_addr)
      {2'b00, OFS_CORE_STATUS_FLAGS}:     read_byte = status_out;
      {2'b00, OFS_PROGRAM_COUNTER_LOW}:   read_byte = pc_low_out;
      {2'b00, OFS_PC_HIGH_LATCH}:         read_byte = {3'b000, pc_high_latch_out};
      {2'b00, OFS_INTERRUPT_CONTROL}:     read_byte = interrupt_control_out;
      {2'b00, OFS_INDIRECT_ADDR_POINTER}: read_byte = indirect_address_pointer_out;
      default:                            read_byte = file_ram[canon_addr];
    endcase
    if (!cell_present) begin
      read_byte = 8'h00;
    end
    next_prdata  = prdata_out;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    if (psel_in && !penable_in) begin
      next_pready  = 1'b1;
      next_pslverr = out_of_range;
      next_prdata  = (pwrite_in || out_of_range) ? 32'h00000000 : {24'h000000, read_byte};
    end
  end

  // Registered answer so the bus outputs come straight from flops
  always_ff @(posedge clk_in or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      prdata_out  <= 32'h00000000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      prdata_out  <= next_prdata;
      pready_out  <= next_pready;
      pslverr_out <= next_pslverr;
    end
  end

endmodule : banked_data_memory_map

// >>> banked_data_memory_map_properties.sv
// Purpose: Port-level assertions for the banked data memory map.
// Assumes: Checker ports carry the names of the block's own ports.
// Notes:   Bound into every instance of the block.
`timescale 1ns/100ps
module banked_data_memory_map_properties
  import banked_data_memory_map_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic        other_reset_in,
  input wire logic        timeout_flag_in,
  input wire logic        power_down_flag_in,
  input wire logic        core_flags_we_in,
  input wire logic [2:0]  core_flags_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic [7:0]  status_out,
  input wire logic [7:0]  interrupt_control_out,
  input wire logic [7:0]  indirect_address_pointer_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////////////////////////////////////
  // Aligned in-range access phases, the steps the hole, indirect and mirror checks build on
  sequence s_ok; psel_in && penable_in && pready_out && paddr_in[31:9] == 0 && paddr_in[1:0] == 0; endsequence
  sequence s_rd; s_ok ##0 !pwrite_in; endsequence
  property p_answer; psel_in && !penable_in |=> pready_out; endproperty
  a_answer: assert property (p_answer) else $error("no ready after setup");
  property p_hole; s_rd ##0 (status_out[6:5] == 2'b11 && paddr_in[8:2] inside {[7'h0d:7'h0f]}) |-> prdata_out == 0; endproperty
  a_hole: assert property (p_hole) else $error("hole read not zero");
  property p_ind; s_rd ##0 (paddr_in[8:2] == 0 && indirect_address_pointer_out[6:0] == 0) |-> prdata_out == 0; endproperty
  a_ind: assert property (p_ind) else $error("indirect self read not zero");
  property p_por; $rose(reset_n_in) |-> status_out == STATUS_POR_VALUE; endproperty
  a_por: assert property (p_por) else $error("status power-on value");
  property p_other; other_reset_in |=> status_out == {3'b000, $past(timeout_flag_in), $past(power_down_flag_in), $past(status_out[2:0])}; endproperty
  a_other: assert property (p_other) else $error("status other-reset value");
  property p_mirror; s_ok ##0 (pwrite_in && paddr_in[8:2] == OFS_INTERRUPT_CONTROL && !other_reset_in) |=> interrupt_control_out == $past(pwdata_in[7:0]); endproperty
  a_mirror: assert property (p_mirror) else $error("mirrored write lost");
  // A register that nobody writes must keep its value, like plain RAM
  property p_hold; !(psel_in && pwrite_in) && !other_reset_in |=> $stable(interrupt_control_out) && $stable(indirect_address_pointer_out); endproperty
  a_hold: assert property (p_hold) else $error("register changed unwritten");
  property p_core; core_flags_we_in && !other_reset_in |=> status_out[2:0] == $past(core_flags_in); endproperty
  a_core: assert property (p_core) else $error("core flags not loaded");
endmodule : banked_data_memory_map_properties
bind banked_data_memory_map banked_data_memory_map_properties chk_u (.*);

// >>> core_datapath_model.sv
// Purpose: Core datapath stand-in issuing flag and PC low writes.
// Assumes: Changes its outputs only just after rising edges.
// Notes:   Random gaps give both back-to-back and sparse writes.
`timescale 1ns/100ps
module core_datapath_model (
  input  wire logic       clk_in,
  input  wire logic       active_in,
  output logic            flags_we_out,
  output logic      [2:0] flags_out,
  output logic            pc_we_out,
  output logic      [7:0] pc_out
);
  int seed = 59;
  // Silent unless the bench lets the core run
  always @(posedge clk_in) begin
    flags_we_out <= active_in && ($random(seed) & 3) == 0;
    pc_we_out <= active_in && ($random(seed) & 1);
    flags_out <= 3'($random(seed));
    pc_out <= 8'($random(seed));
  end
endmodule : core_datapath_model

// >>> banked_data_memory_map_test.sv
// Purpose: Self-checking bench for the banked data memory map.
// Assumes: One APB transfer is a setup cycle plus one access cycle.
// Notes:   RAM counts as unknown (-1) until the bench writes it.
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin num_errors++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module banked_data_memory_map_test import banked_data_memory_map_pkg::*;;
  logic        clk_in = 0, reset_n_in = 0, orst = 0, to_q = 0, pd_q = 0, psel = 0, pen = 0, pwr = 0, run = 0, e;
  logic [31:0] paddr = 0, pwdata = 0, prdata, r;
  logic        pready, pslverr, fwe, pwe;
  logic [2:0]  fl;
  logic [7:0]  st_o, pcl_o, ic_o, ptr_o, pcl_i;
  logic [4:0]  pch_o;
  int          num_errors = 0, compares = 0, seed = 59, cyc = 0, live = 0, d, a, wa, mem [512] = '{default: -1};
  always #12.5 clk_in = ~clk_in;
  banked_data_memory_map dut_u (.clk_in, .reset_n_in, .other_reset_in(orst), .timeout_flag_in(to_q),
    .power_down_flag_in(pd_q), .core_flags_we_in(fwe), .core_flags_in(fl), .pc_low_we_in(pwe), .pc_low_in(pcl_i),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .status_out(st_o), .pc_low_out(pcl_o), .pc_high_latch_out(pch_o),
    .interrupt_control_out(ic_o), .indirect_address_pointer_out(ptr_o));
  core_datapath_model core_u (.clk_in, .active_in(run), .flags_we_out(fwe), .flags_out(fl), .pc_we_out(pwe),
    .pc_out(pcl_i));
  ////////////////////////////////////////////////////////////////////////
  // Model: file address of a bank offset after mirroring, -1 with no storage
  function automatic int fa(int b, int o);
    if (o inside {1, 2, 3, 4, 10, 11} || o >= 'h70) return o == 1 ? (b & 1) * 128 + 1 : o;
    return (b * 128 + o) inside {['h18d:'h18f]} ? -1 : b * 128 + o;
  endfunction : fa
  function automatic int res(int o);
    if (o != 0) return fa((mem[3] >> 5) & 3, o);
    return (mem[4] & 127) == 0 ? -1 : fa((mem[3] >> 6) & 2 | (mem[4] >> 7), mem[4] & 127);
  endfunction : res
  // Reference update and output compare, both on pre-edge values
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 8000) begin num_errors++; tally_and_finish(); end
    live = reset_n_in ? live + 1 : 0;
    if (live > 3) `CHK("regs", {8'(mem[3]), 8'(mem[2]), 5'(mem[10]), 8'(mem[11]), 8'(mem[4])}, {st_o, pcl_o, pch_o, ic_o, ptr_o})
    if (live < 3) begin
      mem[2] = 0;
      mem[3] = 'h18;
      mem[4] = 0;
      mem[10] = 0;
      mem[11] = 0;
    end else if (orst) begin
      mem[2] = 0;
      mem[3] = to_q * 16 + pd_q * 8 + (mem[3] & 7);
      mem[10] = 0;
      mem[11] = mem[11] & 1;
    end else begin
      // Refused addresses never reach a cell
      wa = (psel && pen && pwr && pready && paddr[31:9] == 0 && paddr[1:0] == 0) ? res(paddr[8:2]) : -1;
      if (wa == 3) mem[3] = pwdata[7:0] & 'he7 | mem[3] & 'h18;
      else if (wa >= 0) mem[wa] = wa == 10 ? pwdata[4:0] : pwdata[7:0];
      if (fwe) mem[3] = mem[3] & 'hf8 | fl;
      if (pwe) mem[2] = pcl_i;
    end
  end
  task automatic xfer(input logic w, input logic [31:0] ad, input logic [31:0] wd);
    @(posedge clk_in);
    {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, ad, wd};
    @(posedge clk_in);
    pen <= 1;
    do @(posedge clk_in); while (pready !== 1'b1);
    {r, e} = {prdata, pslverr};
    {psel, pen} <= 2'b00;
  endtask : xfer
  task automatic rd_chk(input int o);
    xfer(0, 32'(o * 4), 0);
    if (res(o) < 0) `CHK("hole", 33'h0, {e, r})
    else if (mem[res(o)] >= 0) `CHK("rdata", 33'(mem[res(o)]), {e, r})
  endtask : rd_chk
  task automatic tally_and_finish;
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Main sequence: random traffic, shared window, holes, refusals, resets
  initial begin
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1;
    repeat (6) @(posedge clk_in);
    for (int n = 0; n < 600; n++) begin
      d = $random(seed);
      a = d[20:18] == 0 ? 3 : d[23:21] == 0 ? 4 : d[14:8];
      if (d[31]) xfer(1, 32'(a * 4), d);
      else rd_chk(a);
    end
    // Shared window: written from one bank, read back from another; ends in bank 3
    for (int b = 0; b < 4; b++) begin
      xfer(1, 12, 32'(b * 32));
      xfer(1, 32'('h1c0 + b * 4), 32'('ha0 + b));
    end
    for (int b = 0; b < 4; b++) begin
      xfer(1, 12, 32'(b * 32));
      rd_chk('h73 - b);
    end
    for (int o = 'h0d; o < 'h10; o++) xfer(1, 32'(o * 4), 'hff);
    for (int o = 'h0d; o < 'h10; o++) rd_chk(o);
    xfer(0, 13, 0);
    `CHK("slverr", 33'h1_0000_0000, {e, r})
    xfer(1, 32'h0000_082c, 32'h0000_0055);
    `CHK("slverr", 33'h1_0000_0000, {e, r})
    run <= 1;
    repeat (40) @(posedge clk_in);
    {to_q, pd_q, orst} <= 3'b101;
    @(posedge clk_in);
    {to_q, pd_q} <= 2'b01;
    @(posedge clk_in);
    {orst, run} <= 2'b00;
    repeat (4) @(posedge clk_in);
    reset_n_in <= 0;
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1;
    repeat (6) @(posedge clk_in);
    rd_chk(0);
    rd_chk(3);
    tally_and_finish();
  end
endmodule : banked_data_memory_map_test
